// ---- core/nrl_logs.sv ----
// Queued non-data capability log, rebuild-assist log and error reporting
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Capability log page is readable whenever the queued non-data command is supported.
// - Capability log is 512 bytes; logging version word reads 0001h.
// - Dword 0 bits 0-4 report abort queue and four abort types.
// - Dword 1 bits 0-2 report deadline, write and read no-continue support.
// - Dword 5 bit 1 reports set-features subcommand support; others reserved.
// - Abort type accepted only when its capability bit is one.
// - Deadline subcommand and its flags honoured exactly as capability bits say.
// - Queued read with bypass bit set ignores rebuild assist entirely.
// - Predicted error on queued read logs sense key Bh, code 1103h.
// - Error entry holds first failing LBA and end of contiguous run.
// - Queued read without unrecovered error completes cleanly.
// - Rebuild-assist log page readable when the feature is supported.
// - Rebuild log layout: enable, length N, mask, bitmap, reserved to 511.
// - Length byte gives mask and bitmap size; host writes to it ignored.
// - Mask shows supported bitmap bits; host writes to it ignored.
// - Disabled element bit one makes its addresses report predicted errors.
// - Disabled element bit zero makes its addresses report no predicted errors.
// - Abort queue request with unsupported abort type is aborted.
// - Enable write runs self-test, fills bitmap, quiets background, enables.
// - Power cycle or enable write of zero disables rebuild assist.
module nrl_logs (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic ncq_nd_sup_i,
   input wire logic rebuild_sup_i,
   input wire logic log_rd_req_i,
   input wire logic [7:0] log_rd_page_i,
   input wire logic [nrl_pkg::ADDR_W-1:0] log_rd_addr_i,
   output logic log_rd_valid_o,
   output logic [7:0] log_rd_data_o,
   output logic log_rd_err_o,
   output logic [15:0] gpl_version_o,
   input wire logic log_wr_req_i,
   input wire logic [nrl_pkg::ADDR_W-1:0] log_wr_addr_i,
   input wire logic [7:0] log_wr_data_i,
   input wire logic log_wr_last_i,
   output logic log_wr_busy_o,
   output logic selftest_start_o,
   input wire logic selftest_done_i,
   input wire logic [nrl_pkg::PE_BITS-1:0] selftest_fail_i,
   output logic bg_minimize_o,
   output logic rebuild_enabled_o,
   output logic [nrl_pkg::PE_BITS-1:0] disabled_elems_o,
   input wire logic nd_req_i,
   input wire logic [4:0] nd_subcmd_i,
   input wire logic [3:0] nd_abort_type_i,
   input wire logic nd_write_no_continue_flag_i,
   input wire logic nd_read_no_continue_flag_i,
   output logic nd_done_o,
   output logic nd_abort_o,
   output logic write_no_continue_flag_o,
   output logic read_no_continue_flag_o,
   input wire logic xfer_req_i,
   input wire logic xfer_write_i,
   input wire logic rebuild_bypass_bit_i,
   input wire logic [nrl_pkg::LBA_W-1:0] xfer_lba_i,
   input wire logic [nrl_pkg::CNT_W-1:0] xfer_count_i,
   output logic xfer_busy_o,
   output logic xfer_done_o,
   output logic xfer_err_o,
   output logic qerr_valid_o,
   output logic [3:0] qerr_sense_key_o,
   output logic [15:0] qerr_asc_o,
   output logic [nrl_pkg::LBA_W-1:0] qerr_lba_o,
   output logic [nrl_pkg::LBA_W-1:0] qerr_final_lba_o
);
   import nrl_pkg::*;

   nrl_rb_state_t rb_state_r;
   logic stage_en_r;
   logic [PE_BITS-1:0] stage_map_r;
   logic stage_en_nxt;
   logic [PE_BITS-1:0] stage_map_nxt;
   logic [PE_BITS-1:0] map_nxt;
   logic commit;
   logic sc_busy;
   logic sc_done;
   logic sc_err;
   logic [LBA_W-1:0] sc_first;
   logic [LBA_W-1:0] sc_last;
   logic sc_start;
   logic xfer_wr_r;
   logic [7:0] rd_byte;
   logic rd_ok;

   // capability page byte; reserved content stays zero
   function automatic logic [7:0] ncq_byte(input logic [ADDR_W-1:0] a);
      logic [31:0] dw;
      dw = '0;
      unique case (a[ADDR_W-1:2])
         DW_ABORT: dw[CAP_ABORT_SELECTED:CAP_ABORT_NCQ] = DEV_ABORT_CAPS;
         DW_DEADLINE: dw[CAP_READ_NO_CONTINUE_FLAG:CAP_DEADLINE] = DEV_DL_CAPS;
         DW_SETFEAT: dw[CAP_SETFEAT] = DEV_SETFEAT_CAP;
         default: dw = '0;
      endcase
      return dw[a[1:0]*8 +: 8];
   endfunction

   // Byte k of a big-endian multi-byte field
   function automatic logic [7:0] field_byte(input logic [PE_BITS-1:0] f, input logic [ADDR_W-1:0] k);
      return f[(PE_LEN - 1 - int'(k)) * 8 +: 8];
   endfunction

   function automatic logic [7:0] rb_byte(input logic [ADDR_W-1:0] a, input logic en,
                                          input logic [PE_BITS-1:0] map);
      logic [7:0] b;
      b = '0;
      if (a == RA_BYTE_EN) begin
         b[0] = en;
      end else if (a == RA_BYTE_LEN) begin
         b = RA_LEN_VAL;
      end else if (a >= RA_MASK_BASE && a < RA_MAP_BASE) begin
         b = field_byte(DEV_PE_MASK, a - RA_MASK_BASE);
      end else if (a >= RA_MAP_BASE && a < RA_MAP_END) begin
         b = field_byte(map, a - RA_MAP_BASE);
      end
      return b;
   endfunction

   // page availability follows the identify flags
   always_comb begin
      rd_ok = 1'b0;
      rd_byte = '0;
      if (log_rd_page_i == LOG_NCQ_ND && ncq_nd_sup_i) begin
         rd_ok = 1'b1;
         rd_byte = ncq_byte(log_rd_addr_i);
      end else if (log_rd_page_i == LOG_REBUILD && rebuild_sup_i) begin
         rd_ok = 1'b1;
         rd_byte = rb_byte(log_rd_addr_i, rebuild_enabled_o, disabled_elems_o);
      end
   end

   // unsupported page returns error and zero data
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         log_rd_valid_o <= 1'b0;
         log_rd_data_o <= '0;
         log_rd_err_o <= 1'b0;
      end else begin
         log_rd_valid_o <= log_rd_req_i;
         log_rd_err_o <= log_rd_req_i & ~rd_ok;
         if (log_rd_req_i) begin
            log_rd_data_o <= rd_byte;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gpl_version_o <= '0;
      end else begin
         gpl_version_o <= GPL_VERSION;
      end
   end

   // only enable and bitmap bytes are staged; length and mask writes drop
   always_comb begin
      stage_en_nxt = stage_en_r;
      stage_map_nxt = stage_map_r;
      if (log_wr_req_i && rb_state_r == RB_IDLE && rebuild_sup_i) begin
         if (log_wr_addr_i == RA_BYTE_EN) begin
            stage_en_nxt = log_wr_data_i[0];
         end
         for (int k = 0; k < PE_LEN; k++) begin
            if (log_wr_addr_i == RA_MAP_BASE + ADDR_W'(k)) begin
               stage_map_nxt[(PE_LEN - 1 - k) * 8 +: 8] = log_wr_data_i;
            end
         end
      end
   end

   // Commit keys on the last flag, not an address; the final byte may be at any address
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stage_en_r <= 1'b0;
         stage_map_r <= '0;
      end else begin
         stage_en_r <= stage_en_nxt;
         stage_map_r <= stage_map_nxt;
      end
   end

   // Writes held off entirely while self-test runs
   assign commit = log_wr_req_i & log_wr_last_i & rebuild_sup_i & (rb_state_r == RB_IDLE);
   // Host bitmap bytes survive enable, merged with self-test failures
   assign map_nxt = (stage_map_r | selftest_fail_i) & DEV_PE_MASK;

   // enable sequence; writes held off while self-test runs
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rb_state_r <= RB_IDLE;
         selftest_start_o <= 1'b0;
         log_wr_busy_o <= 1'b0;
      end else begin
         selftest_start_o <= 1'b0;
         unique case (rb_state_r)
            RB_IDLE: begin
               if (commit && stage_en_nxt) begin
                  rb_state_r <= RB_TEST;
                  selftest_start_o <= 1'b1;
                  log_wr_busy_o <= 1'b1;
               end
            end
            RB_TEST: begin
               if (selftest_done_i) begin
                  rb_state_r <= RB_IDLE;
                  log_wr_busy_o <= 1'b0;
               end
            end
         endcase
      end
   end

   // bitmap from self-test; disable on zero write or reset
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rebuild_enabled_o <= 1'b0;
         bg_minimize_o <= 1'b0;
         disabled_elems_o <= '0;
      end else if (rb_state_r == RB_TEST && selftest_done_i) begin
         disabled_elems_o <= map_nxt;
         bg_minimize_o <= 1'b1;
         rebuild_enabled_o <= 1'b1;
      end else if (commit && !stage_en_nxt) begin
         // Bitmap bits outside the mask cannot be set by the host
         disabled_elems_o <= stage_map_nxt & DEV_PE_MASK;
         bg_minimize_o <= 1'b0;
         rebuild_enabled_o <= 1'b0;
      end
   end

   // abort type check, deadline support, unknown subcommand aborts
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         nd_done_o <= 1'b0;
         nd_abort_o <= 1'b0;
      end else begin
         nd_done_o <= nd_req_i;
         nd_abort_o <= 1'b0;
         if (nd_req_i) begin
            // Abilities are package constants; a leaner part edits only those
            unique case (nd_subcmd_i)
               SUB_ABORT: begin
                  unique case (nd_abort_type_i)
                     AT_ALL: nd_abort_o <= ~DEV_ABORT_CAPS[CAP_ABORT_ALL];
                     AT_STREAM: nd_abort_o <= ~DEV_ABORT_CAPS[CAP_ABORT_STREAM];
                     AT_NONSTREAM: nd_abort_o <= ~DEV_ABORT_CAPS[CAP_ABORT_NONSTREAM];
                     AT_SELECTED: nd_abort_o <= ~DEV_ABORT_CAPS[CAP_ABORT_SELECTED];
                     default: nd_abort_o <= 1'b1;
                  endcase
                  if (!DEV_ABORT_CAPS[CAP_ABORT_NCQ]) begin
                     nd_abort_o <= 1'b1;
                  end
               end
               SUB_DEADLINE: nd_abort_o <= ~DEV_DL_CAPS[CAP_DEADLINE];
               SUB_SETFEAT: nd_abort_o <= ~DEV_SETFEAT_CAP;
               default: nd_abort_o <= 1'b1;
            endcase
         end
      end
   end

   // no-continue flags stored only when supported; power cycle clears
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         write_no_continue_flag_o <= 1'b0;
         read_no_continue_flag_o <= 1'b0;
      end else if (nd_req_i && nd_subcmd_i == SUB_DEADLINE && DEV_DL_CAPS[CAP_DEADLINE]) begin
         write_no_continue_flag_o <= nd_write_no_continue_flag_i & DEV_DL_CAPS[CAP_WRITE_NO_CONTINUE_FLAG];
         read_no_continue_flag_o <= nd_read_no_continue_flag_i & DEV_DL_CAPS[CAP_READ_NO_CONTINUE_FLAG];
      end
   end

   // Requests arriving while a walk is running are dropped
   assign sc_start = xfer_req_i & ~sc_busy;

   nrl_scan u_scan (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .start_i(sc_start),
      // bypass bit disables checking for reads only
      .check_en_i(rebuild_enabled_o & (xfer_write_i | ~rebuild_bypass_bit_i)),
      .lba_i(xfer_lba_i),
      .count_i(xfer_count_i),
      .disabled_i(disabled_elems_o),
      .busy_o(sc_busy),
      .done_o(sc_done),
      .err_o(sc_err),
      .first_o(sc_first),
      .last_o(sc_last)
   );

   // Direction kept so writes report errors but log no entry
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         xfer_wr_r <= 1'b0;
         xfer_busy_o <= 1'b0;
      end else begin
         xfer_busy_o <= sc_start | (sc_busy & ~sc_done);
         if (sc_start) begin
            xfer_wr_r <= xfer_write_i;
         end
      end
   end

   // clean completion; error entry logged for reads
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         xfer_done_o <= 1'b0;
         xfer_err_o <= 1'b0;
         qerr_valid_o <= 1'b0;
         qerr_sense_key_o <= '0;
         qerr_asc_o <= '0;
         qerr_lba_o <= '0;
         qerr_final_lba_o <= '0;
      end else begin
         xfer_done_o <= sc_done;
         xfer_err_o <= sc_done & sc_err;
         qerr_valid_o <= sc_done & sc_err & ~xfer_wr_r;
         if (sc_done && sc_err && !xfer_wr_r) begin
            qerr_sense_key_o <= SENSE_ABORTED;
            qerr_asc_o <= ASC_MULTI_READ;
            qerr_lba_o <= sc_first;
            qerr_final_lba_o <= sc_last;
         end
      end
   end
endmodule // nrl_logs
`default_nettype wire

// ---- core/nrl_scan.sv ----
// Sector walker that finds the first run of predicted-error sectors
`timescale 1ns/1ps
`default_nettype none
module nrl_scan (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic start_i,
   input wire logic check_en_i,
   input wire logic [nrl_pkg::LBA_W-1:0] lba_i,
   input wire logic [nrl_pkg::CNT_W-1:0] count_i,
   input wire logic [nrl_pkg::PE_BITS-1:0] disabled_i,
   output logic busy_o,
   output logic done_o,
   output logic err_o,
   output logic [nrl_pkg::LBA_W-1:0] first_o,
   output logic [nrl_pkg::LBA_W-1:0] last_o
);
   import nrl_pkg::*;

   nrl_sc_state_t state_r;
   logic [LBA_W-1:0] cur_r;
   logic [CNT_W:0] left_r;
   logic chk_r;
   logic found_r;
   logic hit;
   logic ends;

   // Disabled element means every sector it holds is a predicted error
   assign hit = chk_r & disabled_i[cur_r[ELEM_SHIFT +: ELEM_IDX_W]];
   assign ends = (left_r == {{CNT_W{1'b0}}, 1'b1}) | (found_r & ~hit);

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= SC_IDLE;
         cur_r <= '0;
         left_r <= '0;
         chk_r <= 1'b0;
      end else begin
         unique case (state_r)
            SC_IDLE: begin
               if (start_i) begin
                  state_r <= SC_SCAN;
                  cur_r <= lba_i;
                  chk_r <= check_en_i;
                  // Zero count means the full 65536 sectors
                  left_r <= (count_i == '0) ? {1'b1, {CNT_W{1'b0}}} : {1'b0, count_i};
               end
            end
            SC_SCAN: begin
               cur_r <= cur_r + 1'b1;
               left_r <= left_r - 1'b1;
               if (ends) begin
                  state_r <= SC_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         found_r <= 1'b0;
         first_o <= '0;
         last_o <= '0;
      end else if (state_r == SC_IDLE) begin
         found_r <= 1'b0;
      end else if (hit) begin
         found_r <= 1'b1;
         last_o <= cur_r;
         if (!found_r) begin
            first_o <= cur_r;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         done_o <= 1'b0;
         err_o <= 1'b0;
      end else begin
         done_o <= (state_r == SC_SCAN) & ends;
         err_o <= (state_r == SC_SCAN) & ends & (found_r | hit);
      end
   end

   assign busy_o = (state_r == SC_SCAN);
endmodule // nrl_scan
`default_nettype wire

// ---- inc/nrl_pkg.sv ----
// Constants and types for the queued capability and rebuild-assist log block
`default_nettype none
package nrl_pkg;
   localparam int unsigned LBA_W = 48;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned PE_LEN = 2;
   localparam int unsigned PE_BITS = PE_LEN * 8;
   localparam int unsigned ELEM_IDX_W = 4;
   localparam int unsigned ELEM_SHIFT = 10;

   localparam logic [7:0] LOG_NCQ_ND = 8'h12;
   localparam logic [7:0] LOG_REBUILD = 8'h15;
   localparam logic [15:0] GPL_VERSION = 16'h0001;

   localparam logic [4:0] SUB_ABORT = 5'h00;
   localparam logic [4:0] SUB_DEADLINE = 5'h01;
   localparam logic [4:0] SUB_SETFEAT = 5'h05;

   localparam logic [3:0] AT_ALL = 4'h0;
   localparam logic [3:0] AT_STREAM = 4'h1;
   localparam logic [3:0] AT_NONSTREAM = 4'h2;
   localparam logic [3:0] AT_SELECTED = 4'h3;

   localparam int unsigned CAP_ABORT_NCQ = 0;
   localparam int unsigned CAP_ABORT_ALL = 1;
   localparam int unsigned CAP_ABORT_STREAM = 2;
   localparam int unsigned CAP_ABORT_NONSTREAM = 3;
   localparam int unsigned CAP_ABORT_SELECTED = 4;
   localparam int unsigned CAP_DEADLINE = 0;
   localparam int unsigned CAP_WRITE_NO_CONTINUE_FLAG = 1;
   localparam int unsigned CAP_READ_NO_CONTINUE_FLAG = 2;
   localparam int unsigned CAP_SETFEAT = 1;

   localparam logic [4:0] DEV_ABORT_CAPS = 5'h1f;
   localparam logic [2:0] DEV_DL_CAPS = 3'h7;
   localparam logic DEV_SETFEAT_CAP = 1'b1;
   localparam logic [PE_BITS-1:0] DEV_PE_MASK = 16'h0fff;

   localparam logic [6:0] DW_ABORT = 7'h00;
   localparam logic [6:0] DW_DEADLINE = 7'h01;
   localparam logic [6:0] DW_SETFEAT = 7'h05;

   localparam logic [ADDR_W-1:0] RA_BYTE_EN = 9'h000;
   localparam logic [ADDR_W-1:0] RA_BYTE_LEN = 9'h007;
   localparam logic [ADDR_W-1:0] RA_MASK_BASE = 9'h008;
   localparam logic [ADDR_W-1:0] RA_MAP_BASE = 9'h00a;
   localparam logic [ADDR_W-1:0] RA_MAP_END = 9'h00c;
   localparam logic [7:0] RA_LEN_VAL = 8'h02;

   localparam logic [3:0] SENSE_ABORTED = 4'hb;
   localparam logic [15:0] ASC_MULTI_READ = 16'h1103;

   typedef enum logic [0:0] {RB_IDLE, RB_TEST} nrl_rb_state_t;
   typedef enum logic [0:0] {SC_IDLE, SC_SCAN} nrl_sc_state_t;
endpackage
`default_nettype wire

// ---- sim/ncq_caps_and_rebuild_assist_logs_test.sv ----
// Self-checking bench for the log block
`timescale 1ns/1ps
`default_nettype none
module ncq_caps_and_rebuild_assist_logs_test;
   logic sys_clk_i = 1'b0;
   logic resetn_i, ncq_nd_sup_i, rebuild_sup_i, log_rd_req_i, log_rd_valid_o, log_rd_err_o;
   logic log_wr_req_i, log_wr_last_i, log_wr_busy_o, selftest_start_o, selftest_done_i;
   logic bg_minimize_o, rebuild_enabled_o, nd_req_i, nd_write_no_continue_flag_i, nd_read_no_continue_flag_i, nd_done_o, nd_abort_o;
   logic write_no_continue_flag_o, read_no_continue_flag_o, xfer_req_i, xfer_write_i;
   logic rebuild_bypass_bit_i, xfer_busy_o, xfer_done_o, xfer_err_o, qerr_valid_o;
   logic [7:0] log_rd_page_i, log_rd_data_o, log_wr_data_i, st_delay;
   logic [8:0] log_rd_addr_i, log_wr_addr_i;
   logic [15:0] gpl_version_o, selftest_fail_i, disabled_elems_o, qerr_asc_o, st_fail, xfer_count_i;
   logic [4:0] nd_subcmd_i;
   logic [3:0] nd_abort_type_i, qerr_sense_key_o;
   logic [47:0] xfer_lba_i, qerr_lba_o, qerr_final_lba_o;
   int fails = 0;
   int samples_checked = 0;
   always #20 sys_clk_i = ~sys_clk_i;
   nrl_logs u_dut (.*);
   nrl_st_model u_st (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .start_i(selftest_start_o),
      .delay_i(st_delay), .fail_i(st_fail), .done_o(selftest_done_i), .fail_o(selftest_fail_i));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] pg, input logic [8:0] a, input logic [7:0] exp, input logic err);
      @(posedge sys_clk_i);
      log_rd_req_i <= 1'b1;
      log_rd_page_i <= pg;
      log_rd_addr_i <= a;
      @(posedge sys_clk_i);
      log_rd_req_i <= 1'b0;
      #1;
      chk({log_rd_valid_o, log_rd_err_o, log_rd_data_o}, {1'b1, err, exp});
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic last);
      @(posedge sys_clk_i);
      log_wr_req_i <= 1'b1;
      log_wr_addr_i <= a;
      log_wr_data_i <= d;
      log_wr_last_i <= last;
      @(posedge sys_clk_i);
      log_wr_req_i <= 1'b0;
      log_wr_last_i <= 1'b0;
      #1;
   endtask
   task automatic nd(input logic [4:0] s, input logic [3:0] t, input logic w, input logic r, input logic ab);
      @(posedge sys_clk_i);
      nd_req_i <= 1'b1;
      nd_subcmd_i <= s;
      nd_abort_type_i <= t;
      nd_write_no_continue_flag_i <= w;
      nd_read_no_continue_flag_i <= r;
      @(posedge sys_clk_i);
      nd_req_i <= 1'b0;
      #1;
      chk({nd_done_o, nd_abort_o}, {1'b1, ab});
   endtask
   task automatic xf(input logic w, input logic b, input logic [47:0] l, input logic [15:0] c,
                     input logic e, input logic [47:0] f, input logic [47:0] z);
      int n;
      @(posedge sys_clk_i);
      xfer_req_i <= 1'b1;
      xfer_write_i <= w;
      rebuild_bypass_bit_i <= b;
      xfer_lba_i <= l;
      xfer_count_i <= c;
      @(posedge sys_clk_i);
      xfer_req_i <= 1'b0;
      #1;
      chk(xfer_busy_o, 1'b1);
      for (n = 0; n < 300 && xfer_done_o !== 1'b1; n++) begin
         @(posedge sys_clk_i);
         #1;
      end
      chk({xfer_done_o, xfer_err_o, qerr_valid_o, xfer_busy_o}, {1'b1, e, e & ~w, 1'b0});
      if (e & ~w) chk({qerr_sense_key_o, qerr_asc_o, qerr_lba_o, qerr_final_lba_o}, {4'hb, 16'h1103, f, z});
   endtask
   task automatic t_caps();
      rd(8'h12, 9'h000, 8'h1f, 1'b0);
      chk(gpl_version_o, 16'h0001);
      rd(8'h12, 9'h003, 8'h00, 1'b0);
      rd(8'h12, 9'h004, 8'h07, 1'b0);
      rd(8'h12, 9'h008, 8'h00, 1'b0);
      rd(8'h12, 9'h014, 8'h02, 1'b0);
      rd(8'h12, 9'h1ff, 8'h00, 1'b0);
      @(posedge sys_clk_i);
      ncq_nd_sup_i <= 1'b0;
      rebuild_sup_i <= 1'b0;
      rd(8'h12, 9'h000, 8'h00, 1'b1);
      rd(8'h15, 9'h000, 8'h00, 1'b1);
      @(posedge sys_clk_i);
      ncq_nd_sup_i <= 1'b1;
      rebuild_sup_i <= 1'b1;
   endtask
   task automatic t_nd();
      for (int t = 0; t < 6; t++) nd(5'h00, 4'(t), 1'b0, 1'b0, t > 3);
      nd(5'h00, 4'hf, 1'b0, 1'b0, 1'b1);
      nd(5'h05, 4'h0, 1'b0, 1'b0, 1'b0);
      nd(5'h02, 4'h0, 1'b0, 1'b0, 1'b1);
      nd(5'h01, 4'h0, 1'b1, 1'b0, 1'b0);
      chk({write_no_continue_flag_o, read_no_continue_flag_o}, 2'b10);
      nd(5'h01, 4'h0, 1'b0, 1'b1, 1'b0);
      chk({write_no_continue_flag_o, read_no_continue_flag_o}, 2'b01);
   endtask
   task automatic t_en(input logic [7:0] dly);
      int n;
      st_delay <= dly;
      st_fail <= 16'h0004;
      wr(9'h000, 8'h01, 1'b0);
      wr(9'h007, 8'hff, 1'b0);
      wr(9'h008, 8'h00, 1'b0);
      wr(9'h00a, 8'h80, 1'b0);
      wr(9'h00b, 8'h01, 1'b1);
      chk({selftest_start_o, log_wr_busy_o}, 2'b11);
      // Disable attempt while self-test runs must be dropped
      wr(9'h000, 8'h00, 1'b1);
      for (n = 0; n < 100 && log_wr_busy_o === 1'b1; n++) begin
         @(posedge sys_clk_i);
         #1;
      end
      chk({rebuild_enabled_o, bg_minimize_o, disabled_elems_o}, {2'b11, 16'h0005});
      rd(8'h15, 9'h000, 8'h01, 1'b0);
      rd(8'h15, 9'h007, 8'h02, 1'b0);
      rd(8'h15, 9'h008, 8'h0f, 1'b0);
      rd(8'h15, 9'h009, 8'hff, 1'b0);
      rd(8'h15, 9'h00a, 8'h00, 1'b0);
      rd(8'h15, 9'h00b, 8'h05, 1'b0);
      rd(8'h15, 9'h00c, 8'h00, 1'b0);
   endtask
   task automatic t_xf();
      xf(1'b0, 1'b0, 48'h3fe, 16'h0004, 1'b1, 48'h3fe, 48'h3ff);
      xf(1'b0, 1'b1, 48'h3fe, 16'h0004, 1'b0, 48'h0, 48'h0);
      xf(1'b0, 1'b0, 48'h400, 16'h0008, 1'b0, 48'h0, 48'h0);
      xf(1'b1, 1'b0, 48'h800, 16'h0002, 1'b1, 48'h0, 48'h0);
   endtask
   task automatic t_dis();
      wr(9'h000, 8'h00, 1'b1);
      chk({rebuild_enabled_o, bg_minimize_o, disabled_elems_o}, {2'b00, 16'h0001});
      xf(1'b0, 1'b0, 48'h3fe, 16'h0004, 1'b0, 48'h0, 48'h0);
      t_en(8'd1);
      @(posedge sys_clk_i);
      resetn_i <= 1'b0;
      @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      #1;
      chk({rebuild_enabled_o, disabled_elems_o}, 17'h0);
   endtask
   initial begin
      {resetn_i, log_rd_req_i, log_wr_req_i, log_wr_last_i, nd_req_i, xfer_req_i} = '0;
      {nd_write_no_continue_flag_i, nd_read_no_continue_flag_i, xfer_write_i, rebuild_bypass_bit_i} = '0;
      {log_rd_page_i, log_rd_addr_i, log_wr_addr_i, log_wr_data_i} = '0;
      {nd_subcmd_i, nd_abort_type_i, xfer_lba_i, xfer_count_i, st_delay, st_fail} = '0;
      {ncq_nd_sup_i, rebuild_sup_i} = 2'b11;
      repeat (6) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      t_caps();
      t_nd();
      t_en(8'd1);
      t_en(8'd20);
      t_xf();
      t_dis();
      report_and_stop();
   end
   initial begin
      #400000;
      fails++;
      report_and_stop();
   end
endmodule // ncq_caps_and_rebuild_assist_logs_test
`default_nettype wire

// ---- sim/nrl_logs_props.sv ----
// Port-level checks for the log block
`timescale 1ns/1ps
`default_nettype none
module nrl_logs_props (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic ncq_nd_sup_i,
   input wire logic rebuild_sup_i,
   input wire logic log_rd_req_i,
   input wire logic [7:0] log_rd_page_i,
   input wire logic [8:0] log_rd_addr_i,
   input wire logic [7:0] log_rd_data_o,
   input wire logic [15:0] gpl_version_o,
   input wire logic log_wr_req_i,
   input wire logic [8:0] log_wr_addr_i,
   input wire logic [7:0] log_wr_data_i,
   input wire logic log_wr_last_i,
   input wire logic log_wr_busy_o,
   input wire logic selftest_done_i,
   input wire logic bg_minimize_o,
   input wire logic rebuild_enabled_o,
   input wire logic nd_req_i,
   input wire logic [4:0] nd_subcmd_i,
   input wire logic [3:0] nd_abort_type_i,
   input wire logic nd_write_no_continue_flag_i,
   input wire logic nd_read_no_continue_flag_i,
   input wire logic nd_done_o,
   input wire logic nd_abort_o,
   input wire logic write_no_continue_flag_o,
   input wire logic read_no_continue_flag_o,
   input wire logic xfer_req_i,
   input wire logic rebuild_bypass_bit_i,
   input wire logic xfer_busy_o,
   input wire logic xfer_done_o,
   input wire logic qerr_valid_o,
   input wire logic [3:0] qerr_sense_key_o,
   input wire logic [15:0] qerr_asc_o
);
   logic byp_r;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // Bypass bit of the transfer in flight
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) byp_r <= 1'b0;
      else if (xfer_req_i && !xfer_busy_o) byp_r <= rebuild_bypass_bit_i;
   end
   abort_caps_a: assert property (log_rd_req_i && ncq_nd_sup_i && log_rd_page_i == 8'h12
      && log_rd_addr_i == 9'h000 |=> log_rd_data_o == 8'h1f) else $error("abort caps byte wrong");
   elem_len_a: assert property (log_rd_req_i && rebuild_sup_i && log_rd_page_i == 8'h15
      && log_rd_addr_i == 9'h007 |=> log_rd_data_o == 8'h02) else $error("element length wrong");
   version_word_a: assert property ($past(resetn_i) |-> gpl_version_o == 16'h0001)
      else $error("version word wrong");
   bad_abort_a: assert property (nd_req_i && (nd_subcmd_i == 5'h00 && nd_abort_type_i > 4'h3
      || !(nd_subcmd_i inside {5'h00, 5'h01, 5'h05})) |=> nd_done_o && nd_abort_o) else $error("not refused");
   good_abort_a: assert property (nd_req_i && nd_subcmd_i == 5'h00 && nd_abort_type_i <= 4'h3
      |=> nd_done_o && !nd_abort_o) else $error("abort type refused");
   nc_flags_a: assert property (nd_req_i && nd_subcmd_i == 5'h01 |=>
      write_no_continue_flag_o == $past(nd_write_no_continue_flag_i) && read_no_continue_flag_o == $past(nd_read_no_continue_flag_i))
      else $error("no-continue flags wrong");
   qerr_fields_a: assert property (qerr_valid_o |-> xfer_done_o && qerr_sense_key_o == 4'hb
      && qerr_asc_o == 16'h1103) else $error("error entry fields wrong");
   bypass_clean_a: assert property (xfer_done_o && byp_r |-> !qerr_valid_o)
      else $error("bypass read logged");
   enable_done_a: assert property (log_wr_busy_o && selftest_done_i |=>
      rebuild_enabled_o && bg_minimize_o && !log_wr_busy_o) else $error("enable not applied");
   disable_wr_a: assert property (log_wr_req_i && log_wr_last_i && rebuild_sup_i && !log_wr_busy_o
      && log_wr_addr_i == 9'h000 && !log_wr_data_i[0] |=> !rebuild_enabled_o && !bg_minimize_o)
      else $error("disable not applied");
endmodule // nrl_logs_props
bind nrl_logs nrl_logs_props u_props (.*);
`default_nettype wire

// ---- sim/nrl_st_model.sv ----
// Self-test engine stand-in answering a start pulse after a set delay
`timescale 1ns/1ps
`default_nettype none
module nrl_st_model (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic start_i,
   input wire logic [7:0] delay_i,
   input wire logic [15:0] fail_i,
   output logic done_o,
   output logic [15:0] fail_o
);
   logic [7:0] cnt_r;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_r <= 8'h00;
         done_o <= 1'b0;
      end else begin
         cnt_r <= start_i ? delay_i : (cnt_r != 8'h00 ? cnt_r - 8'h01 : 8'h00);
         done_o <= cnt_r == 8'h01;
      end
   end
   // Result only valid with done; garbage otherwise so stale use shows
   assign fail_o = done_o ? fail_i : ~fail_i;
endmodule // nrl_st_model
`default_nettype wire
